// file: rtl/nma_map.svh
/*
  Register offsets, command codes, field positions and the address clamp
  value used by the native max address reporter.
  Assumes it is included by bare name from files that need these constants.
*/
`ifndef NMA_MAP_SVH
`define NMA_MAP_SVH

// ==========================================================================
// Register byte offsets on the Avalon-MM slave
`define NMA_OFF_CMD     5'h00
`define NMA_OFF_ERR     5'h04
`define NMA_OFF_STAT    5'h08
`define NMA_OFF_SECT    5'h0c
`define NMA_OFF_CYLL    5'h10
`define NMA_OFF_CYLH    5'h14
`define NMA_OFF_DEVH    5'h18
`define NMA_OFF_DCTL    5'h1c

// ==========================================================================
// Command codes
`define NMA_CODE_NATIVE     8'hf8
`define NMA_CODE_NATIVE_EXT 8'h27

// ==========================================================================
// Values and field positions
`define NMA_LBA28_CLAMP   28'hfffffff
`define NMA_ERR_ABORT_BIT 2
`define NMA_ERR_ABORT     8'h04
`define NMA_ST_BUSY_BIT   7
`define NMA_ST_READY_BIT  6
`define NMA_ST_ERR_BIT    0
`define NMA_DEVH_LBA_BIT  6
`define NMA_DEVH_DEV_BIT  4
`define NMA_DEVH_FIXED    8'ha0
`define NMA_DCTL_HOB_BIT  7
`define NMA_BYTE_ZERO     8'h00
`define NMA_WORD_ZERO     32'h00000000

`endif

// file: rtl/nma_pkg.sv
/*
  Types shared by the native max address reporter: engine states and the
  packed state record of the top module.
  Assumes nothing of its surroundings.
*/
`default_nettype none
package nma_pkg;

  // ========================================================================
  // Command engine states
  typedef enum logic {
    ST_IDLE,
    ST_RUN
  } engine_state_e;

  // ========================================================================
  // Whole state of the top module
  typedef struct packed {
    engine_state_e st;        // Engine state
    logic [7:0]    cmd;       // Command code taken
    logic          lba_mode;  // Addressing-mode bit
    logic          dev;       // Device select bit
    logic          hob;       // High-order-byte select
    logic          ready;     // Drive ready, sampled
    logic          busy;      // Busy flag
    logic          err_bit;   // Error summary flag
    logic [7:0]    err;       // Error register
    logic [23:0]   lo;        // Sector, cyl low, cyl high
    logic [23:0]   hi;        // Previous bytes of the same
    logic [3:0]    head;      // Head field
    logic          wait_hold; // Waitrequest level
    logic [31:0]   rdata;     // Read data
  } core_s;

endpackage : nma_pkg
`default_nettype wire

// file: rtl/max_address_formatter.sv
/*
  Formats the drive's native maximum address into task-file byte fields
  for the 28-bit query in LBA or CHS form, and the 48-bit query in LBA form.
  Assumes purely combinational use by the reporter; geometry inputs stable.
*/
`timescale 1ns/100ps
`default_nettype none
`include "nma_map.svh"
module max_address_formatter (
  input  wire logic        ext,
  input  wire logic        lba_mode,
  input  wire logic [47:0] native_max_lba,
  input  wire logic [15:0] chs_max_cylinder,
  input  wire logic [3:0]  chs_max_head,
  input  wire logic [7:0]  chs_max_sector,
  output logic      [23:0] low_bytes,
  output logic      [23:0] high_bytes,
  output logic      [3:0]  head_bits
);
  localparam int LANES = 3;
  logic [27:0] src28;  // 28-bit view of the result
  logic        over;   // Native max above 28-bit reach

  // ========================================================================
  // Source selection
  // Upper 20 bits nonzero means above the 28-bit limit
  assign over = |native_max_lba[47:28];

  always_comb begin
    if (ext) begin
      src28 = native_max_lba[27:0];                      // RULE_09
    end else if (!lba_mode) begin
      // CHS packs as head, cylinder, sector
      src28 = {chs_max_head, chs_max_cylinder, chs_max_sector}; // RULE_07
    end else if (over) begin
      src28 = `NMA_LBA28_CLAMP;                          // RULE_03
    end else begin
      src28 = native_max_lba[27:0];                      // RULE_02
    end
  end

  // ========================================================================
  // Byte lanes: sector, cylinder low, cylinder high
  genvar i;
  generate
    for (i = 0; i < LANES; i++) begin : g_lane
      assign low_bytes[8*i +: 8]  = src28[8*i +: 8];    // RULE_04
      assign high_bytes[8*i +: 8] = ext ? native_max_lba[24+8*i +: 8]
                                        : `NMA_BYTE_ZERO;
    end
  endgenerate

  // Head field only carries bits 27:24 for the 28-bit query
  assign head_bits = ext ? 4'h0 : src28[27:24];          // RULE_06
endmodule : max_address_formatter
`default_nettype wire

// file: rtl/native_max_address_reporter.sv
/*
  Task-file command handling for the native max address queries, reached
  over an Avalon-MM slave with waitrequest.
  Assumes one clock, synchronous inputs, and drive geometry held stable
  by the media bookkeeping logic outside.
*/
// What this block does
// RULE_01 - Code f8 starts the 28-bit query
// RULE_02 - 28-bit query ignores any set-max limit
// RULE_03 - Clamp 28-bit result to 268,435,455
// RULE_04 - LBA mode: bits 7:0 in sector
// RULE_05 - LBA mode: bits 15:8, 23:16 in cylinders
// RULE_06 - LBA mode: bits 27:24 in head field
// RULE_07 - CHS mode: max sector, cylinder, head reported
// RULE_08 - Code 27 starts the 48-bit query
// RULE_09 - 48-bit query ignores extended set-max limit
// RULE_10 - Sector reads 7:0 or 31:24 by select
// RULE_11 - Cylinder low reads 15:8 or 39:32
// RULE_12 - Cylinder high reads 23:16 or 47:40
// RULE_13 - Only abort bit may be set after completion
// RULE_14 - Busy, fault, corrected clear; error only if aborted
`timescale 1ns/100ps
`default_nettype none
`include "nma_map.svh"
module native_max_address_reporter (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        ce,
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  input  wire logic        drive_ready,
  input  wire logic [47:0] native_max_lba,
  input  wire logic [15:0] chs_max_cylinder,
  input  wire logic [3:0]  chs_max_head,
  input  wire logic [7:0]  chs_max_sector,
  output logic             command_busy
);
  import nma_pkg::*;

  // ========================================================================
  // Declarations
  core_s       state_reg;   // Registered state
  core_s       state_next;  // Next state
  logic        is_ext;      // Command taken is the 48-bit query
  logic        known_c;     // Command code recognised
  logic        abort_c;     // Command must be aborted
  logic        commit_c;    // Write takes effect this edge
  logic [23:0] fmt_lo;      // Formatted low bytes
  logic [23:0] fmt_hi;      // Formatted high bytes
  logic [3:0]  fmt_head;    // Formatted head bits
  logic [7:0]  status_c;    // Status byte as read
  logic [7:0]  devh_c;      // Device/head byte as read
  logic [31:0] rmux_c;      // Read data selection

  // ========================================================================
  // Result formatting
  max_address_formatter u_fmt (
    .ext              (is_ext),
    .lba_mode         (state_reg.lba_mode),
    .native_max_lba   (native_max_lba),
    .chs_max_cylinder (chs_max_cylinder),
    .chs_max_head     (chs_max_head),
    .chs_max_sector   (chs_max_sector),
    .low_bytes        (fmt_lo),
    .high_bytes       (fmt_hi),
    .head_bits        (fmt_head)
  );

  // ========================================================================
  // Command decode
  // The extended query always answers in LBA form
  assign is_ext  = (state_reg.cmd == `NMA_CODE_NATIVE_EXT);     // RULE_08
  assign known_c = (state_reg.cmd == `NMA_CODE_NATIVE) || is_ext; // RULE_01
  // Unknown codes and a not-ready drive both abort
  assign abort_c = !known_c || !state_reg.ready;

  // Write lands on the edge where the master sees waitrequest low
  assign commit_c = write && !state_reg.wait_hold && byteenable[0]
                    && (address[1:0] == 2'b00);

  // ========================================================================
  // Readback fields
  always_comb begin
    status_c = `NMA_BYTE_ZERO;
    // Fault, seek, request and corrected bits stay zero
    status_c[`NMA_ST_BUSY_BIT]  = state_reg.busy;             // RULE_14
    status_c[`NMA_ST_READY_BIT] = state_reg.ready;
    status_c[`NMA_ST_ERR_BIT]   = state_reg.err_bit;
    devh_c = `NMA_DEVH_FIXED;
    devh_c[`NMA_DEVH_LBA_BIT] = state_reg.lba_mode;
    devh_c[`NMA_DEVH_DEV_BIT] = state_reg.dev;
    devh_c[3:0] = state_reg.head;
  end

  // Read multiplexer, unmapped offsets read as zero
  always_comb begin
    rmux_c = `NMA_WORD_ZERO;
    case (address)
      `NMA_OFF_CMD,
      `NMA_OFF_STAT: begin
        rmux_c[7:0] = status_c;
      end
      `NMA_OFF_ERR: begin
        rmux_c[7:0] = state_reg.err;
      end
      `NMA_OFF_SECT: begin
        rmux_c[7:0] = state_reg.hob ? state_reg.hi[7:0]
                                    : state_reg.lo[7:0];      // RULE_10
      end
      `NMA_OFF_CYLL: begin
        rmux_c[7:0] = state_reg.hob ? state_reg.hi[15:8]
                                    : state_reg.lo[15:8];     // RULE_11
      end
      `NMA_OFF_CYLH: begin
        rmux_c[7:0] = state_reg.hob ? state_reg.hi[23:16]
                                    : state_reg.lo[23:16];    // RULE_12
      end
      `NMA_OFF_DEVH: begin
        rmux_c[7:0] = devh_c;
      end
      `NMA_OFF_DCTL: begin
        rmux_c[`NMA_DCTL_HOB_BIT] = state_reg.hob;
      end
      default: begin
        rmux_c = `NMA_WORD_ZERO;
      end
    endcase
  end

  // ========================================================================
  // Next-state logic
  always_comb begin
    state_next = state_reg;
    state_next.ready = drive_ready;

    // Bus handshake: one wait cycle, then a single-cycle answer
    if ((read || write) && state_reg.wait_hold) begin
      state_next.wait_hold = 1'b0;
      if (read) begin
        state_next.rdata = rmux_c;
      end
    end else begin
      state_next.wait_hold = 1'b1;
    end

    // Register writes
    if (commit_c) begin
      case (address)
        `NMA_OFF_CMD: begin
          // Commands written while busy are dropped, as a drive would
          if (!state_reg.busy) begin
            state_next.cmd     = writedata[7:0];
            state_next.busy    = 1'b1;
            state_next.err     = `NMA_BYTE_ZERO;
            state_next.err_bit = 1'b0;
            state_next.st      = ST_RUN;
          end
        end
        `NMA_OFF_DEVH: begin
          state_next.lba_mode = writedata[`NMA_DEVH_LBA_BIT];
          state_next.dev      = writedata[`NMA_DEVH_DEV_BIT];
        end
        `NMA_OFF_DCTL: begin
          state_next.hob = writedata[`NMA_DCTL_HOB_BIT];
        end
        default: begin
          state_next.hob = state_reg.hob;
        end
      endcase
    end

    // Command engine
    case (state_reg.st)
      ST_IDLE: begin
        state_next.st = state_next.st;
      end
      ST_RUN: begin
        state_next.busy = 1'b0;                               // RULE_14
        state_next.st   = ST_IDLE;
        if (abort_c) begin
          state_next.err     = `NMA_ERR_ABORT;                // RULE_13
          state_next.err_bit = 1'b1;                          // RULE_14
        end else begin
          state_next.err     = `NMA_BYTE_ZERO;                // RULE_13
          state_next.err_bit = 1'b0;
          state_next.lo      = fmt_lo;                        // RULE_05
          state_next.hi      = fmt_hi;
          state_next.head    = fmt_head;
        end
      end
      default: begin
        state_next.st = ST_IDLE;
      end
    endcase
  end

  // ========================================================================
  // State register, frozen while ce is low
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= '{st: ST_IDLE, cmd: 8'h00, lba_mode: 1'b0,
                     dev: 1'b0, hob: 1'b0, ready: 1'b0, busy: 1'b0,
                     err_bit: 1'b0, err: 8'h00, lo: 24'h000000,
                     hi: 24'h000000, head: 4'h0, wait_hold: 1'b1,
                     rdata: 32'h00000000};
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  // ========================================================================
  // Outputs, straight from flip-flops
  assign readdata     = state_reg.rdata;
  assign waitrequest  = state_reg.wait_hold;
  assign command_busy = state_reg.busy;

  // ========================================================================
  // Assertions
  // A frozen clock enable holds state, so checks pause with it
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn || !ce);

  // Command write accepted by the slave
  sequence s_cmd_taken;
    commit_c && (address == `NMA_OFF_CMD) && !state_reg.busy;
  endsequence

  // Engine finishing a query without abort
  sequence s_query_ok;
    state_reg.st == ST_RUN && !abort_c;
  endsequence

  a_cmd_busy_pulse: assert property ( // RULE_01
    s_cmd_taken |=> state_reg.busy ##1 !state_reg.busy)
    else $error("command did not run busy for one cycle");

  a_bus_answer: assert property (
    (read || write) && waitrequest |=> !waitrequest)
    else $error("slave did not answer in one cycle");

  a_lba_clamp_value: assert property ( // RULE_03
    s_query_ok and (!is_ext && state_reg.lba_mode
      && (|native_max_lba[47:28]))
    |=> {state_reg.head, state_reg.lo} == `NMA_LBA28_CLAMP)
    else $error("28-bit result not clamped");

  a_lba28_bytes: assert property ( // RULE_04
    s_query_ok and (!is_ext && state_reg.lba_mode
      && !(|native_max_lba[47:28]))
    |=> {state_reg.head, state_reg.lo} == $past(native_max_lba[27:0]))
    else $error("28-bit LBA fields wrong");

  a_chs_fields: assert property ( // RULE_07
    s_query_ok and (!is_ext && !state_reg.lba_mode)
    |=> state_reg.lo[7:0] == $past(chs_max_sector)
        && state_reg.lo[23:8] == $past(chs_max_cylinder)
        && state_reg.head == $past(chs_max_head))
    else $error("CHS fields wrong");

  a_ext_low_bytes: assert property ( // RULE_10
    s_query_ok and is_ext
    |=> state_reg.lo == $past(native_max_lba[23:0]))
    else $error("48-bit low bytes wrong");

  a_ext_high_bytes: assert property ( // RULE_12
    s_query_ok and is_ext
    |=> state_reg.hi == $past(native_max_lba[47:24]))
    else $error("48-bit high bytes wrong");

  a_error_only_abort: assert property ( // RULE_13
    state_reg.st == ST_RUN
    |=> (state_reg.err & ~`NMA_ERR_ABORT) == `NMA_BYTE_ZERO
        && state_reg.err[`NMA_ERR_ABORT_BIT] == $past(abort_c))
    else $error("error register carries more than abort");

  a_status_done: assert property ( // RULE_14
    state_reg.st == ST_RUN
    |=> !status_c[`NMA_ST_BUSY_BIT]
        && status_c[`NMA_ST_ERR_BIT] == $past(abort_c)
        && status_c[5:2] == 4'h0)
    else $error("status wrong after completion");

  // ========================================================================
  // Result field checks, one field group at a time; then busy, handshake and freeze checks

  // Engine finishing a query that must abort
  sequence s_query_abort;
    state_reg.st == ST_RUN && abort_c;
  endsequence

  // Engine finishing a 28-bit LBA query at or below the clamp value
  sequence s_query_lba28;
    s_query_ok and (!is_ext && state_reg.lba_mode
      && !(|native_max_lba[47:28]));
  endsequence

  // Cylinder bytes carry the middle of the 28-bit address
  a_lba28_cyl_bytes: assert property ( // RULE_05
    s_query_lba28
    |=> state_reg.lo[23:8] == $past(native_max_lba[23:8]))
    else $error("28-bit cylinder bytes wrong");

  // Head field carries the top nibble of the 28-bit address
  a_lba28_head_bits: assert property ( // RULE_06
    s_query_lba28
    |=> state_reg.head == $past(native_max_lba[27:24]))
    else $error("28-bit head bits wrong");

  // The extended answer lives in the byte registers only
  a_ext_head_zero: assert property ( // RULE_09
    s_query_ok and is_ext |=> state_reg.head == 4'h0)
    else $error("48-bit query left head bits set");

  // Cylinder low: current byte and previous byte of the 48-bit value
  a_ext_mid_bytes: assert property ( // RULE_11
    s_query_ok and is_ext
    |=> state_reg.lo[15:8] == $past(native_max_lba[15:8])
        && state_reg.hi[15:8] == $past(native_max_lba[39:32]))
    else $error("48-bit cylinder low bytes wrong");

  // An abort must not disturb an earlier good answer
  a_abort_keeps: assert property ( // RULE_13
    s_query_abort
    |=> $stable(state_reg.lo) && $stable(state_reg.hi)
        && $stable(state_reg.head))
    else $error("aborted query changed result fields");

  // Busy output drops once the engine has run
  a_busy_ends: assert property ( // RULE_14
    state_reg.st == ST_RUN |=> !command_busy)
    else $error("busy still high after the query ran");

  // Answer stands one cycle, so a held request is not taken twice
  a_wait_one_cycle: assert property (
    !waitrequest |=> waitrequest)
    else $error("waitrequest low for more than one cycle");

  // Ce low must freeze every flop, the bus handshake included;
  // this one keeps watching while ce is low
  a_freeze_hold: assert property (
    disable iff (!resetn)
    !ce |=> $stable(state_reg))
    else $error("state moved while clock enable was low");

endmodule : native_max_address_reporter
`default_nettype wire

// file: tb/host_adapter_model.sv
/*
  Host adapter model: an Avalon-MM master for the task-file registers.
  Assumes one clock and a slave that answers by dropping waitrequest.
*/
`timescale 1ns/100ps
`default_nettype none
module host_adapter_model (
  input  wire logic        clk,
  input  wire logic [31:0] readdata,
  input  wire logic        waitrequest,
  output logic      [4:0]  address,
  output logic             read,
  output logic             write,
  output logic      [31:0] writedata,
  output logic      [3:0]  byteenable,
  output logic             timed_out
);
  // ==========================================================================
  // Idle bus at time zero
  initial begin
    address    = 5'h00;
    read       = 1'b0;
    write      = 1'b0;
    writedata  = 32'h00000000;
    byteenable = 4'h0;
    timed_out  = 1'b0;
  end

  // Request stays put until waitrequest is seen low; bounded so a hang ends
  task automatic wait_ack();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 64);
    if (n >= 64) timed_out <= 1'b1;
  endtask : wait_ack

  // One byte in bits 7:0, lane 0 enabled
  task automatic bus_write(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    address    <= a;
    writedata  <= {24'h000000, d};
    byteenable <= 4'h1;
    write      <= 1'b1;
    wait_ack();
    write      <= 1'b0;
  endtask : bus_write

  // Data taken at the same edge that sees waitrequest low
  task automatic bus_read(input logic [4:0] a, output logic [31:0] d);
    @(posedge clk);
    address <= a;
    read    <= 1'b1;
    wait_ack();
    d = readdata;
    read    <= 1'b0;
  endtask : bus_read
endmodule : host_adapter_model
`default_nettype wire

// file: tb/native_max_address_reporter_bench.sv
/*
  Self-checking bench for the native max address reporter.
  Assumes the host adapter model and the register map header.
*/
`timescale 1ns/100ps
`default_nettype none
`include "nma_map.svh"
module native_max_address_reporter_bench;
  // ==========================================================================
  // Signals
  logic        clk, resetn, ready, ce;
  logic [4:0]  address;
  logic        read, write, waitrequest, busy, tmo;
  logic [31:0] writedata, readdata;
  logic [3:0]  byteenable, head;
  logic [47:0] lba;
  logic [15:0] cyl;
  logic [7:0]  sect;
  int          fail_count, checked;

  native_max_address_reporter dut (
    .clk(clk), .resetn(resetn), .ce(ce), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .drive_ready(ready),
    .native_max_lba(lba), .chs_max_cylinder(cyl), .chs_max_head(head),
    .chs_max_sector(sect), .command_busy(busy));

  host_adapter_model host (
    .clk(clk), .readdata(readdata), .waitrequest(waitrequest),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .timed_out(tmo));

  // ==========================================================================
  // Clock, and a hang cut short
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge tmo) begin
    fail_count++;
    complete_run();
  end

  // ==========================================================================
  // Helpers
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic rd(input string nm, input logic [4:0] a, input logic [7:0] e);
    logic [31:0] d;
    host.bus_read(a, d);
    chk(nm, {24'h000000, e}, d);
  endtask : rd

  // Device/head first, then the code; poll busy under a bound
  task automatic issue(input logic [7:0] dh, input logic [7:0] code);
    logic [31:0] d;
    int n;
    host.bus_write(`NMA_OFF_DEVH, dh);
    host.bus_write(`NMA_OFF_CMD, code);
    // Busy is launched by the commit edge; look at it half a cycle later
    @(negedge clk);
    chk("busy_set", 32'h00000001, {31'h00000000, busy});
    n = 0;
    do begin
      host.bus_read(`NMA_OFF_STAT, d);
      n++;
    end while (d[7] !== 1'b0 && n < 20);
    chk("busy_clear", 32'h00000000, {31'h00000000, busy});
    if (n >= 20) begin
      fail_count++;
      complete_run();
    end
  endtask : issue

  task automatic regs(input logic [7:0] s, l, h, dh, e, st);
    rd("sector", `NMA_OFF_SECT, s);
    rd("cyl_low", `NMA_OFF_CYLL, l);
    rd("cyl_high", `NMA_OFF_CYLH, h);
    rd("dev_head", `NMA_OFF_DEVH, dh);
    rd("error", `NMA_OFF_ERR, e);
    rd("status", `NMA_OFF_STAT, st);
  endtask : regs

  task automatic geo(input logic [47:0] l, input logic r);
    @(posedge clk);
    lba   <= l;
    ready <= r;
  endtask : geo

  // ==========================================================================
  // Scenarios
  task automatic t_lba28();
    geo(48'h00000abcdef1, 1'b1);
    issue(8'h40, `NMA_CODE_NATIVE);
    regs(8'hf1, 8'hde, 8'hbc, 8'hea, 8'h00, 8'h40);
    $display("test lba28 done");
  endtask : t_lba28

  task automatic t_chs();
    issue(8'h10, `NMA_CODE_NATIVE);
    regs(8'h3f, 8'h34, 8'h12, 8'hb9, 8'h00, 8'h40);
    $display("test chs done");
  endtask : t_chs

  // Just past the 28-bit range, and far beyond it
  task automatic t_clamp();
    geo(48'h000010000000, 1'b1);
    issue(8'h40, `NMA_CODE_NATIVE);
    regs(8'hff, 8'hff, 8'hff, 8'hef, 8'h00, 8'h40);
    geo(48'h800000000001, 1'b1);
    issue(8'h40, `NMA_CODE_NATIVE);
    regs(8'hff, 8'hff, 8'hff, 8'hef, 8'h00, 8'h40);
    $display("test clamp done");
  endtask : t_clamp

  // Unknown code, then drive not ready: abort only, results kept
  task automatic t_abort();
    issue(8'h40, 8'h20);
    regs(8'hff, 8'hff, 8'hff, 8'hef, `NMA_ERR_ABORT, 8'h41);
    geo(48'h000000000001, 1'b0);
    issue(8'h40, `NMA_CODE_NATIVE);
    regs(8'hff, 8'hff, 8'hff, 8'hef, `NMA_ERR_ABORT, 8'h01);
    $display("test abort done");
  endtask : t_abort

  // Extended query, both halves through the high-order select
  task automatic t_ext();
    geo(48'h9a8b7c6d5e4f, 1'b1);
    issue(8'h40, `NMA_CODE_NATIVE_EXT);
    regs(8'h4f, 8'h5e, 8'h6d, 8'he0, 8'h00, 8'h40);
    host.bus_write(`NMA_OFF_DCTL, 8'h80);
    rd("sector_hob", `NMA_OFF_SECT, 8'h7c);
    rd("cyl_low_hob", `NMA_OFF_CYLL, 8'h8b);
    rd("cyl_high_hob", `NMA_OFF_CYLH, 8'h9a);
    rd("dctl_hob", `NMA_OFF_DCTL, 8'h80);
    host.bus_write(`NMA_OFF_DCTL, 8'h00);
    rd("sector_cur", `NMA_OFF_SECT, 8'h4f);
    rd("cmd_status", `NMA_OFF_CMD, 8'h40);
    $display("test ext done");
  endtask : t_ext

  // Clock enable low holds the slave; the read is answered once it rises
  task automatic t_freeze();
    logic [31:0] d;
    @(posedge clk);
    ce <= 1'b0;
    fork
      host.bus_read(`NMA_OFF_SECT, d);
      begin
        repeat (6) @(posedge clk);
        chk("wait_frozen", 32'h00000001, {31'h00000000, waitrequest});
        ce <= 1'b1;
      end
    join
    chk("sector_frozen", 32'h0000004f, d);
    $display("test freeze done");
  endtask : t_freeze

  // ==========================================================================
  // Verdict
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run

  // ==========================================================================
  // Main sequence: reset 16 cycles, then scenarios
  initial begin
    fail_count = 0;
    checked    = 0;
    resetn     = 1'b0;
    ready      = 1'b1;
    ce         = 1'b1;
    lba        = 48'h000000000000;
    cyl        = 16'h1234;
    head       = 4'h9;
    sect       = 8'h3f;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    t_lba28();
    t_chs();
    t_clamp();
    t_abort();
    t_ext();
    t_freeze();
    complete_run();
  end
endmodule : native_max_address_reporter_bench
`default_nettype wire
